/* File: iicp_defs.svh */
`ifndef IICP_DEFS_SVH
`define IICP_DEFS_SVH

// Register byte offsets on the APB slave
`define IICP_OFF_WARP 8'h00
`define IICP_OFF_LED_EN 8'h04
`define IICP_OFF_DRV_R 8'h08
`define IICP_OFF_DRV_G 8'h0c
`define IICP_OFF_DRV_B 8'h10
`define IICP_OFF_ALGO_LO 8'h14
`define IICP_OFF_ALGO_HI 8'h18
`define IICP_OFF_BRIGHT 8'h1c
`define IICP_OFF_LUT_ADDR 8'h20
`define IICP_OFF_LUT_DATA 8'h24
`define IICP_OFF_DB_CTRL 8'h28
`define IICP_OFF_CAL_R 8'h2c
`define IICP_OFF_CAL_G 8'h30
`define IICP_OFF_CAL_B 8'h34
`define IICP_OFF_CSC_BASE 8'h40
`define IICP_OFF_CSC_LAST 8'h60

// Reset values
`define IICP_LED_EN_RST 3'h0
`define IICP_DRV_RST 10'h000
`define IICP_ALGO_RST 7'h00
`define IICP_BRIGHT_RST 16'h0000
`define IICP_DB_RST 2'h0
`define IICP_CAL_RST 10'h000

// Field limits and encodings
`define IICP_DRV_MAX 10'h36a
`define IICP_ALGO_AVAIL 7'h37
`define IICP_BRIGHT_POS 16'sh03ff
`define IICP_BRIGHT_NEG 16'shfc00
`define IICP_CSC_ONE 12'h400
`define IICP_CSC_FRAC 10
`define IICP_PIX_MAX 12'hfff
`define IICP_WP_SHIFT 2

`endif

/* File: iicp_pkg.sv */
package iicp_pkg;

   // Three 10-bit channels, red in the low bits
   typedef struct packed {
      logic [9:0] b;
      logic [9:0] g;
      logic [9:0] r;
   } iicp_rgb10_t;

   // Three 12-bit channels, red in the low bits
   typedef struct packed {
      logic [11:0] b;
      logic [11:0] g;
      logic [11:0] r;
   } iicp_rgb12_t;

   // Image algorithm enables, one per command byte
   typedef struct packed {
      logic wide_range;
      logic dynamic_black;
      logic white_point;
      logic multi_primary;
      logic color_adjust;
      logic degamma;
      logic chroma_transient_filter;
   } iicp_algo_t;

   // Colour matrix, nine signed s1.10 coefficients, row major
   typedef struct packed {
      logic [8:0][11:0] c;
   } iicp_mat_t;

endpackage

/* File: iicp_lut_mem.sv */
`timescale 1ns/1ps
module iicp_lut_mem
(
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wr_en,
   input wire logic [9:0] wr_addr,
   input wire logic [11:0] wr_data,
   // Read port
   input wire logic [9:0] rd_addr,
   output logic [11:0] rd_data
);

   logic [11:0] mem [0:1023];
   logic [11:0] rd_data_r;

   // Table write
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read
   always_ff @(posedge clk)
   begin
      rd_data_r <= mem[rd_addr];
   end

   assign rd_data = rd_data_r;

endmodule // iicp_lut_mem

/* File: iicp_csc.sv */
`timescale 1ns/1ps
`include "iicp_defs.svh"
module iicp_csc
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pixel in
   input wire logic in_valid,
   input wire iicp_pkg::iicp_rgb12_t in_pix,
   // Coefficients
   input wire iicp_pkg::iicp_mat_t mat,
   // Pixel out
   output logic out_valid,
   output iicp_pkg::iicp_rgb12_t out_pix
);

   logic [2:0][11:0] in_a;
   logic [2:0][11:0] res;
   logic out_valid_r;
   logic [2:0][11:0] out_r;

   assign in_a = in_pix;

   // One row of the matrix per output channel
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_row
         logic signed [26:0] acc;
         logic signed [26:0] scl;
         always_comb
         begin
            acc = 27'sd0;
            for (int j = 0; j < 3; j++)
            begin
               acc = acc + 27'($signed(mat.c[i * 3 + j]) * $signed({1'b0, in_a[j]}));
            end
            scl = acc >>> `IICP_CSC_FRAC;
            if (scl < 27'sd0)
            begin
               res[i] = 12'h000;
            end
            else if (scl > 27'($signed({1'b0, `IICP_PIX_MAX})))
            begin
               res[i] = `IICP_PIX_MAX;
            end
            else
            begin
               res[i] = scl[11:0];
            end
         end
      end
   endgenerate

   // Output stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_valid_r <= 1'b0;
         out_r <= '0;
      end
      else
      begin
         out_valid_r <= in_valid;
         out_r <= res;
      end
   end

   assign out_valid = out_valid_r;
   assign out_pix = out_r;

endmodule // iicp_csc

/* File: iicp_illum_image_cmd.sv */
`timescale 1ns/1ps
`include "iicp_defs.svh"
module iicp_illum_image_cmd
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Warp engine status
   input wire logic warp_modified,
   // Light sensor feedback
   input wire iicp_pkg::iicp_rgb10_t sensor_level,
   // Pixel input
   input wire logic pix_in_valid,
   input wire iicp_pkg::iicp_rgb10_t pix_in,
   // Pixel output
   output logic pix_out_valid,
   output iicp_pkg::iicp_rgb12_t pix_out,
   // LED driver
   output logic [2:0] led_enable,
   output iicp_pkg::iicp_rgb10_t drive_level,
   // Algorithm state
   output iicp_pkg::iicp_algo_t algo_enable
);

   // Stored parameters
   logic warp_mod_r;
   logic [2:0] led_en_r;
   logic [2:0][9:0] drv_r;
   iicp_pkg::iicp_algo_t algo_r;
   logic [15:0] bright_r;
   logic [9:0] lut_addr_r;
   logic [1:0] db_shift_r;
   logic [2:0][9:0] cal_r;
   iicp_pkg::iicp_mat_t mat_r;
   // Bus answer
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] rd_nxt;
   logic setup;
   logic wr_acc;
   logic addr_ok;
   // LED outputs
   logic [2:0] led_en_out_r;
   logic [2:0][9:0] drv_out_r;
   logic [2:0][9:0] drv_nxt;
   logic [2:0][9:0] sens_a;
   // Pixel path
   logic [2:0][9:0] pix_a;
   logic [2:0][9:0] raw1_r;
   logic v1_r;
   logic [2:0][11:0] lut_q;
   logic [2:0][11:0] stg1;
   iicp_pkg::iicp_mat_t mat_use;
   logic csc_valid;
   iicp_pkg::iicp_rgb12_t csc_pix;
   logic [2:0][11:0] csc_a;
   logic [2:0][11:0] pix_nxt;
   logic [2:0][11:0] pix_out_r;
   logic pix_v_r;
   logic [10:0] bias;
   logic lut_we;
   // Which algorithms this device provides
   logic [6:0] avail;

   assign sens_a = sensor_level;
   assign pix_a = pix_in;
   assign csc_a = csc_pix;
   assign avail = `IICP_ALGO_AVAIL;

   // Clamp a written drive level to the LED limit
   function automatic logic [9:0] clamp_drive(input logic [15:0] v);
      if (v > {6'h00, `IICP_DRV_MAX})
      begin
         return `IICP_DRV_MAX;
      end
      return v[9:0];
   endfunction

   // Clamp a signed trimmed level to the LED range
   function automatic logic [9:0] clamp_trim(input logic signed [12:0] v);
      if (v < 13'sd0)
      begin
         return 10'h000;
      end
      if (v > $signed({3'b000, `IICP_DRV_MAX}))
      begin
         return `IICP_DRV_MAX;
      end
      return v[9:0];
   endfunction

   // Saturate an s13.2 brightness to the s8.2 coefficient range
   function automatic logic [10:0] sat_bright(input logic [15:0] v);
      if ($signed(v) > `IICP_BRIGHT_POS)
      begin
         return 11'h3ff;
      end
      if ($signed(v) < `IICP_BRIGHT_NEG)
      begin
         return 11'h400;
      end
      return v[10:0];
   endfunction

   // Index of a colour matrix word, valid only inside the matrix window
   function automatic logic [3:0] csc_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - `IICP_OFF_CSC_BASE;
      return d[5:2];
   endfunction

   // Address decode shared by read and write
   function automatic logic is_csc(input logic [7:0] a);
      return (a >= `IICP_OFF_CSC_BASE) && (a <= `IICP_OFF_CSC_LAST) && (a[1:0] == 2'b00);
   endfunction

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;

   // Mapped address check
   always_comb
   begin
      case (paddr)
         `IICP_OFF_WARP, `IICP_OFF_LED_EN, `IICP_OFF_DRV_R, `IICP_OFF_DRV_G,
         `IICP_OFF_DRV_B, `IICP_OFF_ALGO_LO, `IICP_OFF_ALGO_HI, `IICP_OFF_BRIGHT,
         `IICP_OFF_LUT_ADDR, `IICP_OFF_LUT_DATA, `IICP_OFF_DB_CTRL, `IICP_OFF_CAL_R,
         `IICP_OFF_CAL_G, `IICP_OFF_CAL_B: addr_ok = 1'b1;
         default: addr_ok = is_csc(paddr);
      endcase
   end

   // Read data selection
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `IICP_OFF_WARP: rd_nxt = {31'h0000_0000, warp_mod_r};
         `IICP_OFF_LED_EN: rd_nxt = {29'h0000_0000, led_en_r};
         `IICP_OFF_DRV_R: rd_nxt = {22'h00_0000, drv_r[0]};
         `IICP_OFF_DRV_G: rd_nxt = {22'h00_0000, drv_r[1]};
         `IICP_OFF_DRV_B: rd_nxt = {22'h00_0000, drv_r[2]};
         `IICP_OFF_ALGO_LO: rd_nxt = {7'h00, algo_r.multi_primary, 7'h00,
            algo_r.color_adjust, 7'h00, algo_r.degamma, 7'h00,
            algo_r.chroma_transient_filter};
         `IICP_OFF_ALGO_HI: rd_nxt = {15'h0000, algo_r.wide_range, 7'h00,
            algo_r.dynamic_black, 7'h00, algo_r.white_point};
         `IICP_OFF_BRIGHT: rd_nxt = {16'h0000, bright_r};
         `IICP_OFF_LUT_ADDR: rd_nxt = {22'h00_0000, lut_addr_r};
         `IICP_OFF_DB_CTRL: rd_nxt = {30'h0000_0000, db_shift_r};
         `IICP_OFF_CAL_R: rd_nxt = {22'h00_0000, cal_r[0]};
         `IICP_OFF_CAL_G: rd_nxt = {22'h00_0000, cal_r[1]};
         `IICP_OFF_CAL_B: rd_nxt = {22'h00_0000, cal_r[2]};
         default:
         begin
            if (is_csc(paddr))
            begin
               rd_nxt = {20'h0_0000, mat_r.c[csc_index(paddr)]};
            end
         end
      endcase
   end

   // Bus answer: ready in the first access cycle, data latched at setup
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup;
         if (setup)
         begin
            pslverr_r <= ~addr_ok;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         end
         else if (pready_r)
         begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // Warp status sampled for readback
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         warp_mod_r <= 1'b0;
      end
      else
      begin
         warp_mod_r <= warp_modified;
      end
   end

   // LED enable and drive levels
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         led_en_r <= `IICP_LED_EN_RST;
         drv_r <= {3{`IICP_DRV_RST}};
      end
      else if (wr_acc)
      begin
         case (paddr)
            `IICP_OFF_LED_EN: led_en_r <= pwdata[2:0];
            `IICP_OFF_DRV_R: drv_r[0] <= clamp_drive(pwdata[15:0]);
            `IICP_OFF_DRV_G: drv_r[1] <= clamp_drive(pwdata[15:0]);
            `IICP_OFF_DRV_B: drv_r[2] <= clamp_drive(pwdata[15:0]);
            default: led_en_r <= led_en_r;
         endcase
      end
   end

   // Algorithm enables, bit 0 of each byte only, absent ones stay zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         algo_r <= `IICP_ALGO_RST;
      end
      else if (wr_acc && (paddr == `IICP_OFF_ALGO_LO))
      begin
         algo_r.chroma_transient_filter <= pwdata[0] & avail[0];
         algo_r.degamma <= pwdata[8] & avail[1];
         algo_r.color_adjust <= pwdata[16] & avail[2];
         algo_r.multi_primary <= pwdata[24] & avail[3];
      end
      else if (wr_acc && (paddr == `IICP_OFF_ALGO_HI))
      begin
         algo_r.white_point <= pwdata[0] & avail[4];
         algo_r.dynamic_black <= pwdata[8] & avail[5];
         algo_r.wide_range <= pwdata[16] & avail[6];
      end
   end

   // Brightness, table pointer, dynamic black step and calibration targets
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bright_r <= `IICP_BRIGHT_RST;
         lut_addr_r <= 10'h000;
         db_shift_r <= `IICP_DB_RST;
         cal_r <= {3{`IICP_CAL_RST}};
      end
      else if (wr_acc)
      begin
         case (paddr)
            `IICP_OFF_BRIGHT: bright_r <= pwdata[15:0];
            `IICP_OFF_LUT_ADDR: lut_addr_r <= pwdata[9:0];
            `IICP_OFF_LUT_DATA: lut_addr_r <= lut_addr_r + 10'h001;
            `IICP_OFF_DB_CTRL: db_shift_r <= pwdata[1:0];
            `IICP_OFF_CAL_R: cal_r[0] <= pwdata[9:0];
            `IICP_OFF_CAL_G: cal_r[1] <= pwdata[9:0];
            `IICP_OFF_CAL_B: cal_r[2] <= pwdata[9:0];
            default: bright_r <= bright_r;
         endcase
      end
   end

   // Colour matrix coefficients, identity after reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mat_r.c <= {`IICP_CSC_ONE, 12'h000, 12'h000, 12'h000, `IICP_CSC_ONE,
            12'h000, 12'h000, 12'h000, `IICP_CSC_ONE};
      end
      else if (wr_acc && is_csc(paddr))
      begin
         mat_r.c[csc_index(paddr)] <= pwdata[11:0];
      end
   end

   // LED drive: white point trim, then dynamic black current cut
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_led
         logic signed [11:0] err;
         logic signed [12:0] trim;
         logic [9:0] wp_lvl;
         assign err = $signed({2'b00, cal_r[i]}) - $signed({2'b00, sens_a[i]});
         assign trim = $signed({3'b000, drv_r[i]}) + 13'(err >>> `IICP_WP_SHIFT);
         assign wp_lvl = algo_r.white_point ? clamp_trim(trim) : drv_r[i];
         assign drv_nxt[i] = algo_r.dynamic_black ? (wp_lvl >> db_shift_r) : wp_lvl;
      end
   endgenerate

   // Registered LED outputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         led_en_out_r <= `IICP_LED_EN_RST;
         drv_out_r <= {3{`IICP_DRV_RST}};
      end
      else
      begin
         led_en_out_r <= led_en_r;
         drv_out_r <= drv_nxt;
      end
   end

   assign lut_we = wr_acc && (paddr == `IICP_OFF_LUT_DATA);

   // De-gamma tables, one per channel, loaded together
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_lut
         iicp_lut_mem u_lut
         (
            .clk(clk),
            .wr_en(lut_we),
            .wr_addr(lut_addr_r),
            .wr_data(pwdata[11:0]),
            .rd_addr(pix_a[i]),
            .rd_data(lut_q[i])
         );
         assign stg1[i] = algo_r.degamma ? lut_q[i] : {raw1_r[i], 2'b00};
      end
   endgenerate

   // Raw pixel held alongside the table read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         v1_r <= 1'b0;
         raw1_r <= '0;
      end
      else
      begin
         v1_r <= pix_in_valid;
         raw1_r <= pix_a;
      end
   end

   // Identity matrix when colour adjustment is off
   always_comb
   begin
      mat_use = mat_r;
      if (!algo_r.color_adjust)
      begin
         mat_use.c = {`IICP_CSC_ONE, 12'h000, 12'h000, 12'h000, `IICP_CSC_ONE,
            12'h000, 12'h000, 12'h000, `IICP_CSC_ONE};
      end
   end

   iicp_csc u_csc
   (
      .clk(clk),
      .rst(rst),
      .in_valid(v1_r),
      .in_pix(stg1),
      .mat(mat_use),
      .out_valid(csc_valid),
      .out_pix(csc_pix)
   );

   // The chroma filter has no chroma channel to act on, so it leaves pixels alone
   assign bias = sat_bright(bright_r);

   // Brightness after the matrix, then dynamic black gain, then clamp
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_bri
         logic signed [13:0] sum;
         logic signed [16:0] gain;
         assign sum = $signed({2'b00, csc_a[i]}) + 14'($signed(bias));
         assign gain = algo_r.dynamic_black ? (17'(sum) <<< db_shift_r) : 17'(sum);
         always_comb
         begin
            if (gain < 17'sd0)
            begin
               pix_nxt[i] = 12'h000;
            end
            else if (gain > $signed({5'h00, `IICP_PIX_MAX}))
            begin
               pix_nxt[i] = `IICP_PIX_MAX;
            end
            else
            begin
               pix_nxt[i] = gain[11:0];
            end
         end
      end
   endgenerate

   // Registered pixel output
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pix_v_r <= 1'b0;
         pix_out_r <= '0;
      end
      else
      begin
         pix_v_r <= csc_valid;
         pix_out_r <= pix_nxt;
      end
   end

   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign led_enable = led_en_out_r;
   assign drive_level = drv_out_r;
   assign algo_enable = algo_r;
   assign pix_out_valid = pix_v_r;
   assign pix_out = pix_out_r;

endmodule // iicp_illum_image_cmd

/* File: iicp_illum_image_cmd_chk.sv */
`timescale 1ns/1ps
module iicp_illum_image_cmd_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Status and outputs
   input wire logic warp_modified,
   input wire logic pix_in_valid,
   input wire logic pix_out_valid,
   input wire logic [2:0] led_enable,
   input wire iicp_pkg::iicp_rgb10_t drive_level,
   input wire iicp_pkg::iicp_algo_t algo_enable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   // Bus answer timing and register contents
   chk_pready_one: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready not a single pulse after setup");
   chk_warp_read: assert property (
      s_setup ##0 (!pwrite && paddr == 8'h00) |=> prdata == {31'h0, $past(warp_modified, 2)})
      else $error("warp status read wrong");
   chk_led_apply: assert property (
      (s_done ##0 (pwrite && paddr == 8'h04)) |-> ##2 led_enable == $past(pwdata[2:0], 2))
      else $error("led mask not applied");
   chk_algo_absent: assert property (!algo_enable.multi_primary && !algo_enable.wide_range)
      else $error("absent algorithm shows enabled");
   chk_algo_upper: assert property (
      s_setup ##0 (!pwrite && (paddr == 8'h14 || paddr == 8'h18))
      |=> (prdata & 32'hfefefefe) == 32'h0)
      else $error("algorithm byte upper bits not zero");
   chk_drive_limit: assert property (
      drive_level.r <= 10'd874 && drive_level.g <= 10'd874 && drive_level.b <= 10'd874)
      else $error("drive level above limit");
   chk_pix_latency: assert property (pix_in_valid |-> ##3 pix_out_valid)
      else $error("pixel output latency wrong");
   chk_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("refused read returns data");
endmodule // iicp_illum_image_cmd_chk

/* File: iicp_host_model.sv */
`timescale 1ns/1ps
module iicp_host_model
(
   // Clock
   input wire logic clk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Stale data is not left on the bus
   endtask
endmodule // iicp_host_model

/* File: iicp_illum_image_cmd_tb.sv */
`timescale 1ns/1ps
module iicp_illum_image_cmd_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er, warp_modified;
   logic pix_in_valid, pix_out_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] led_enable;
   iicp_pkg::iicp_rgb10_t sensor_level, pix_in, drive_level;
   iicp_pkg::iicp_rgb12_t pix_out;
   iicp_pkg::iicp_algo_t algo_enable;
   int bad_count, num_checks;

   // Clock and device
   initial clk = 1'b0;
   always #10 clk = ~clk;
   iicp_illum_image_cmd u_iicp_illum_image_cmd (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .warp_modified(warp_modified),
      .sensor_level(sensor_level), .pix_in_valid(pix_in_valid), .pix_in(pix_in),
      .pix_out_valid(pix_out_valid), .pix_out(pix_out), .led_enable(led_enable),
      .drive_level(drive_level), .algo_enable(algo_enable));
   iicp_host_model u_iicp_host_model (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Comparison and bus helpers
   task automatic check(input string n, input logic [35:0] e, input logic [35:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_iicp_host_model.xfer(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      u_iicp_host_model.xfer(1'b0, a, 32'h0, rd, er);
      check(n, {4'h0, e}, {4'h0, rd});
   endtask

   // Warp status bit follows the input
   task automatic t_warp;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk) warp_modified <= i[0];
         rdc("warp", 8'h00, i);
      end
   endtask

   // Every LED mask reaches the pins and reads back
   task automatic t_led;
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h04, m);
         repeat (2) @(posedge clk);
         check("led_pin", m, led_enable);
         rdc("led_reg", 8'h04, m);
      end
   endtask

   // Drive levels at, above and below the limit
   task automatic t_drive;
      wr(8'h08, 32'd874);
      wr(8'h0c, 32'd875);
      wr(8'h10, 32'd5);
      repeat (3) @(posedge clk);
      check("drive_pin", {6'h0, 10'd5, 10'd874, 10'd874}, drive_level);
      rdc("drive_r", 8'h08, 32'd874);
      rdc("drive_g", 8'h0c, 32'd874);
      rdc("drive_b", 8'h10, 32'd5);
   endtask

   // All enable bytes with loose bits set; absent features read zero
   task automatic t_algo;
      wr(8'h14, 32'hffffffff);
      wr(8'h18, 32'hffffffff);
      rdc("algo_lo", 8'h14, 32'h00010101);
      rdc("algo_hi", 8'h18, 32'h00000101);
      check("algo_pin", 7'h37, algo_enable);
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h0);
      rdc("algo_off", 8'h14, 32'h0);
      u_iicp_host_model.xfer(1'b0, 8'h3c, 32'h0, rd, er);
      check("unmapped_err", 1'b1, er);
      check("unmapped_data", 32'h0, rd);
   endtask

   // One pixel through the path with a given bias
   task automatic t_pix(input logic [9:0] v, input logic [15:0] b, input logic [11:0] e);
      wr(8'h1c, {16'h0, b});
      rdc("bright", 8'h1c, {16'h0, b});
      @(posedge clk);
      pix_in_valid <= 1'b1;
      pix_in <= {v, v, v};
      @(posedge clk);
      pix_in_valid <= 1'b0;
      for (int i = 0; i < 8 && pix_out_valid !== 1'b1; i++) @(posedge clk);
      check("pix_valid", 1'b1, pix_out_valid);
      check("pix", {e, e, e}, pix_out);
   endtask

   // De-gamma table entry used only while enabled
   task automatic t_gamma;
      wr(8'h20, 32'h010);
      wr(8'h24, 32'habc);
      wr(8'h14, 32'h00000100);
      t_pix(10'h010, 16'h0000, 12'habc);
      wr(8'h14, 32'h0);
      t_pix(10'h010, 16'h0000, 12'h040);
   endtask

   // Matrix used only with colour adjust; dynamic black and white point on the LEDs
   task automatic t_adj;
      wr(8'h40, 32'h200);
      wr(8'h50, 32'h200);
      wr(8'h60, 32'h200);
      rdc("csc_rd", 8'h50, 32'h200);
      wr(8'h14, 32'h00010000);
      t_pix(10'h100, 16'h0000, 12'h200);
      wr(8'h14, 32'h0);
      t_pix(10'h100, 16'h0000, 12'h400);
      wr(8'h28, 32'h1);
      wr(8'h18, 32'h00000100);
      t_pix(10'h100, 16'h0000, 12'h800);
      check("drive_db", {6'h00, 10'h002, 10'h1b5, 10'h1b5}, drive_level);
      @(posedge clk) sensor_level <= {10'h000, 10'h000, 10'h028};
      wr(8'h30, 32'h64);
      wr(8'h34, 32'h28);
      wr(8'h18, 32'h1);
      repeat (2) @(posedge clk);
      check("drive_wp", {6'h00, 10'h00f, 10'h36a, 10'h360}, drive_level);
      wr(8'h18, 32'h0);
   endtask

   // Closing report
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      warp_modified = 1'b0;
      sensor_level = '0;
      pix_in_valid = 1'b0;
      pix_in = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_warp();
      t_led();
      t_drive();
      t_algo();
      t_pix(10'h3ff, 16'h0000, 12'hffc);
      t_pix(10'h100, 16'h0004, 12'h404);
      t_pix(10'h010, 16'hfff8, 12'h038);
      t_pix(10'h000, 16'h7fff, 12'h3ff);
      t_pix(10'h3ff, 16'h8000, 12'hbfc);
      t_gamma();
      t_adj();
      print_verdict();
   end
endmodule // iicp_illum_image_cmd_tb

bind iicp_illum_image_cmd iicp_illum_image_cmd_chk u_iicp_illum_image_cmd_chk (.clk(clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .warp_modified(warp_modified), .pix_in_valid(pix_in_valid),
   .pix_out_valid(pix_out_valid), .led_enable(led_enable), .drive_level(drive_level),
   .algo_enable(algo_enable));
